//--- design/pfc_feature_bank.sv
// Contract
// - Feature set numbers 0 to 15 are architected and 16 upward are implementation sets.
// - Implementation sets run upward from 16 without gaps, so status tells which exist.
// - A query for an unsupported architected set returns invalid argument, -2.
// - A set number above the highest supported returns -8, failure -3, success 0.
// - Each valid set reports implemented, current setting and controllable 64-bit vectors.
// - An update changes only setting bits that are implemented and controllable.
// - A controllable flag counts only where its feature is implemented.
// - Controllable settings are 0 after reset and no handler entry alters them.
// - With bit 63 set, each bus error drives bus-init unless bus-init is disabled.
// - With bit 62 set, each machine-check abort drives bus error unless that is disabled.
// - With bit 61 set, each machine-check abort drives bus-init unless that is disabled.
// - With bit 60 set, corrected checks become aborts and escalate further, if enabled.
// - With bit 59 set, references go to memory, no coherence requests, snoops miss.
module pfc_feature_bank (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Feature query and update calls
    input wire logic call_valid_in,
    input wire logic call_update_in,
    input wire logic [7:0] call_set_in,
    input wire logic [63:0] call_data_in,
    output logic resp_valid_out,
    output logic [7:0] resp_status_out,
    output logic [63:0] resp_avail_out,
    output logic [63:0] resp_settings_out,
    output logic [63:0] resp_control_out,
    // Error events and signalling enables
    input wire logic bus_error_pin_in,
    input wire logic machine_check_abort_in,
    input wire logic corrected_check_interrupt_in,
    input wire logic bus_initialization_signal_enable_in,
    input wire logic bus_error_signal_enable_in,
    input wire logic mca_enable_in,
    output logic bus_initialization_signal_out,
    output logic bus_error_signal_out,
    output logic machine_check_abort_out,
    // Cache traffic gating
    input wire logic ref_valid_in,
    input wire logic ref_hit_in,
    input wire logic coherence_req_in,
    input wire logic castout_req_in,
    input wire logic snoop_valid_in,
    input wire logic snoop_hit_in,
    output logic ref_from_cache_out,
    output logic ref_to_memory_out,
    output logic coherence_req_out,
    output logic castout_req_out,
    output logic snoop_resp_valid_out,
    output logic snoop_resp_hit_out,
    output logic cache_disabled_out
);
    logic [63:0] settings_r;
    logic [63:0] settings_nxt;
    logic [7:0] status_nxt;
    logic [63:0] writable;
    logic bus_error_signal_s1_r;
    logic bus_error_signal_s2_r;
    logic bus_error_signal_s3_r;
    logic bus_error_signal_level_r;
    logic bus_error_signal_evt;
    logic cache_off;

    // Writable only where implemented and controllable
    assign writable = pfc_pkg::SET0_AVAIL & pfc_pkg::SET0_CONTROL;

    function automatic logic [7:0] set_status(input logic [7:0] set, input logic upd);
        logic [7:0] st;
        st = pfc_pkg::ST_OK;
        if (set > pfc_pkg::SET_MAX) begin
            st = pfc_pkg::ST_BEYOND_MAX;
        end else if (set >= pfc_pkg::SET_IMPL_BASE) begin
            // Implementation set is fixed, so an update fails
            st = upd ? pfc_pkg::ST_FAILED : pfc_pkg::ST_OK;
        end else if (set != pfc_pkg::SET_ARCH_BASE) begin
            st = pfc_pkg::ST_INVALID_ARG;
        end
        return st;
    endfunction : set_status

    always_comb begin
        status_nxt = set_status(call_set_in, call_update_in);
        settings_nxt = settings_r;
        if (call_valid_in && call_update_in && call_set_in == pfc_pkg::SET_ARCH_BASE) begin
            settings_nxt = (settings_r & ~writable) | (call_data_in & writable);
        end
    end

    // Only reset and set-zero update calls change settings; handler entries have no path here
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            settings_r <= pfc_pkg::SET0_RESET;
        end else begin
            settings_r <= settings_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            resp_valid_out <= 1'b0;
            resp_status_out <= pfc_pkg::ST_OK;
            resp_avail_out <= 64'h0;
            resp_settings_out <= 64'h0;
            resp_control_out <= 64'h0;
        end else begin
            resp_valid_out <= call_valid_in;
            if (call_valid_in) begin
                resp_status_out <= status_nxt;
                if (status_nxt != pfc_pkg::ST_OK) begin
                    resp_avail_out <= 64'h0;
                    resp_settings_out <= 64'h0;
                    resp_control_out <= 64'h0;
                end else if (call_set_in == pfc_pkg::SET_ARCH_BASE) begin
                    resp_avail_out <= pfc_pkg::SET0_AVAIL;
                    resp_settings_out <= settings_nxt;
                    resp_control_out <= pfc_pkg::SET0_CONTROL;
                end else begin
                    resp_avail_out <= pfc_pkg::SET16_AVAIL;
                    resp_settings_out <= pfc_pkg::SET16_STATUS;
                    resp_control_out <= pfc_pkg::SET16_CONTROL;
                end
            end
        end
    end

    // Bus error pin is asynchronous; count a rising change once stages agree
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bus_error_signal_s1_r <= 1'b0;
            bus_error_signal_s2_r <= 1'b0;
            bus_error_signal_s3_r <= 1'b0;
            bus_error_signal_level_r <= 1'b0;
        end else begin
            bus_error_signal_s1_r <= bus_error_pin_in;
            bus_error_signal_s2_r <= bus_error_signal_s1_r;
            bus_error_signal_s3_r <= bus_error_signal_s2_r;
            if (bus_error_signal_s2_r == bus_error_signal_s3_r) begin
                bus_error_signal_level_r <= bus_error_signal_s3_r;
            end
        end
    end

    assign bus_error_signal_evt = bus_error_signal_s2_r & bus_error_signal_s3_r & ~bus_error_signal_level_r;

    pfc_escalate u_escalate (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .bus_error_evt_in(bus_error_signal_evt),
        .machine_check_abort_in(machine_check_abort_in),
        .corrected_check_interrupt_in(corrected_check_interrupt_in),
        .bus_error_signal_to_bus_initialization_signal_in(settings_r[pfc_pkg::BIT_BUS_ERROR_SIGNAL_TO_BUS_INITIALIZATION_SIGNAL]),
        .mca_to_bus_error_signal_in(settings_r[pfc_pkg::BIT_MCA_TO_BUS_ERROR_SIGNAL]),
        .mca_to_bus_initialization_signal_in(settings_r[pfc_pkg::BIT_MCA_TO_BUS_INITIALIZATION_SIGNAL]),
        .corrected_check_interrupt_to_mca_in(settings_r[pfc_pkg::BIT_CORRECTED_CHECK_INTERRUPT_TO_MCA]),
        .bus_initialization_signal_enable_in(bus_initialization_signal_enable_in),
        .bus_error_signal_enable_in(bus_error_signal_enable_in),
        .mca_enable_in(mca_enable_in),
        .bus_initialization_signal_out(bus_initialization_signal_out),
        .bus_error_signal_out(bus_error_signal_out),
        .machine_check_abort_out(machine_check_abort_out)
    );

    assign cache_off = settings_r[pfc_pkg::BIT_CACHE_DISABLE];

    // Cache contents are not trusted while disabled; semaphores lose atomicity
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ref_from_cache_out <= 1'b0;
            ref_to_memory_out <= 1'b0;
            cache_disabled_out <= 1'b0;
        end else begin
            ref_from_cache_out <= ref_valid_in & ref_hit_in & ~cache_off;
            ref_to_memory_out <= ref_valid_in & (cache_off | ~ref_hit_in);
            cache_disabled_out <= cache_off;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            coherence_req_out <= 1'b0;
            castout_req_out <= 1'b0;
        end else begin
            coherence_req_out <= coherence_req_in & ~cache_off;
            castout_req_out <= castout_req_in & ~cache_off;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            snoop_resp_valid_out <= 1'b0;
            snoop_resp_hit_out <= 1'b0;
        end else begin
            snoop_resp_valid_out <= snoop_valid_in;
            snoop_resp_hit_out <= snoop_valid_in & snoop_hit_in & ~cache_off;
        end
    end

    sequence s_call_arch_bad;
        call_valid_in && call_set_in > pfc_pkg::SET_ARCH_BASE
            && call_set_in <= pfc_pkg::SET_ARCH_LAST;
    endsequence

    sequence s_call_beyond;
        call_valid_in && call_set_in > pfc_pkg::SET_MAX;
    endsequence

    sequence s_update_set0;
        call_valid_in && call_update_in && call_set_in == pfc_pkg::SET_ARCH_BASE;
    endsequence

    AST_ARCH_INVALID: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_call_arch_bad |=> resp_valid_out && resp_status_out == 8'hfe)
        else $error("unsupported architected set not refused");

    AST_BEYOND_MAX: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_call_beyond |=> resp_valid_out && resp_status_out == 8'hf8)
        else $error("set beyond maximum not reported");

    AST_IMPL_FIRST: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        call_valid_in && !call_update_in && call_set_in == 8'h10
        |=> resp_status_out == 8'h00)
        else $error("first implementation set not supported");

    AST_MASKED_WRITE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_update_set0 |=> settings_r == (($past(settings_r) & ~writable)
            | ($past(call_data_in) & writable)))
        else $error("update touched protected bits");

    AST_STABLE_NO_CALL: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !call_valid_in |=> $stable(settings_r))
        else $error("settings changed without update call");

    AST_RESET_ZERO: assert property (@(posedge sys_clk_in)
        sys_rst_in |=> (settings_r & writable) == 64'h0)
        else $error("controllable settings not cleared at reset");

    AST_SET0_VECTORS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        call_valid_in && call_set_in == 8'h00 && !call_update_in
        |=> resp_settings_out == settings_r && resp_avail_out == pfc_pkg::SET0_AVAIL)
        else $error("set zero vectors wrong");

    AST_SNOOP_MISS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        snoop_valid_in && cache_off |=> snoop_resp_valid_out && !snoop_resp_hit_out)
        else $error("snoop hit while cache disabled");

    AST_NO_COHERENCE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        cache_off ##1 cache_off |-> !coherence_req_out && !castout_req_out)
        else $error("coherence traffic while cache disabled");

    AST_IMPL_UPD_FAIL: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        call_valid_in && call_update_in && call_set_in == pfc_pkg::SET_IMPL_BASE
        |=> resp_valid_out && resp_status_out == 8'hfd)
        else $error("update to fixed set not failed");

    AST_ARCH_ZERO_OK: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        call_valid_in && call_set_in == pfc_pkg::SET_ARCH_BASE
        |=> resp_valid_out && resp_status_out == 8'h00)
        else $error("architected set zero not accepted");

    AST_BAD_ZERO_VEC: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_call_beyond |=> resp_avail_out == 64'h0 && resp_settings_out == 64'h0
            && resp_control_out == 64'h0)
        else $error("vectors returned for missing set");

    AST_RESP_PULSE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !call_valid_in |=> !resp_valid_out)
        else $error("answer without call");

    AST_IMPL_VECTORS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        call_valid_in && !call_update_in && call_set_in == pfc_pkg::SET_IMPL_BASE
        |=> resp_avail_out == pfc_pkg::SET16_AVAIL
            && resp_control_out == pfc_pkg::SET16_CONTROL)
        else $error("implementation set vectors wrong");

    AST_CTRL_SUBSET: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        resp_valid_out && resp_status_out == 8'h00
        |-> (resp_control_out & ~resp_avail_out) == 64'h0)
        else $error("controllable flag on missing feature");

    AST_REF_TO_MEM: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ref_valid_in && cache_off
        |=> ref_to_memory_out && !ref_from_cache_out)
        else $error("reference served by disabled cache");

    AST_REF_FROM_CACHE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ref_valid_in && ref_hit_in && !cache_off
        |=> ref_from_cache_out && !ref_to_memory_out)
        else $error("cache hit not served by cache");

    AST_CASTOUT_PASS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        castout_req_in && coherence_req_in && !cache_off
        |=> castout_req_out && coherence_req_out)
        else $error("traffic blocked while cache enabled");

    AST_BUS_ERROR_SIGNAL_ONE_EVT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        bus_error_signal_evt |=> !bus_error_signal_evt)
        else $error("bus error pin counted twice");

    AST_OTHER_SET_KEEP: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        call_valid_in && call_update_in && call_set_in != pfc_pkg::SET_ARCH_BASE
        |=> $stable(settings_r))
        else $error("update to other set changed settings");

    AST_CACHE_FLAG: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> cache_disabled_out == $past(cache_off))
        else $error("cache disabled flag wrong");
endmodule : pfc_feature_bank

//--- design/pfc_pkg.sv
package pfc_pkg;
    localparam int unsigned FEAT_W = 64;
    localparam int unsigned SET_W = 8;
    localparam int unsigned STAT_W = 8;

    // Feature set numbering
    localparam logic [7:0] SET_ARCH_BASE = 8'h00;
    localparam logic [7:0] SET_ARCH_LAST = 8'h0f;
    localparam logic [7:0] SET_IMPL_BASE = 8'h10;
    localparam logic [7:0] SET_MAX = 8'h10;

    // Return status codes, two's complement
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_INVALID_ARG = 8'hfe;
    localparam logic [7:0] ST_FAILED = 8'hfd;
    localparam logic [7:0] ST_BEYOND_MAX = 8'hf8;

    // Bit positions within feature set zero
    localparam int unsigned BIT_BUS_ERROR_SIGNAL_TO_BUS_INITIALIZATION_SIGNAL = 63;
    localparam int unsigned BIT_MCA_TO_BUS_ERROR_SIGNAL = 62;
    localparam int unsigned BIT_MCA_TO_BUS_INITIALIZATION_SIGNAL = 61;
    localparam int unsigned BIT_CORRECTED_CHECK_INTERRUPT_TO_MCA = 60;
    localparam int unsigned BIT_CACHE_DISABLE = 59;

    // Set zero: implemented and controllable vectors, settings reset
    localparam logic [63:0] SET0_AVAIL = 64'hf800_0000_0000_0000;
    localparam logic [63:0] SET0_CONTROL = 64'hf800_0000_0000_0000;
    localparam logic [63:0] SET0_RESET = 64'h0000_0000_0000_0000;

    // Set sixteen: implementation-specific, fixed
    localparam logic [63:0] SET16_AVAIL = 64'h0000_0000_0000_0000;
    localparam logic [63:0] SET16_CONTROL = 64'h0000_0000_0000_0000;
    localparam logic [63:0] SET16_STATUS = 64'h0000_0000_0000_0000;
endpackage : pfc_pkg

//--- design/pfc_escalate.sv
module pfc_escalate (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic bus_error_evt_in,
    input wire logic machine_check_abort_in,
    input wire logic corrected_check_interrupt_in,
    input wire logic bus_error_signal_to_bus_initialization_signal_in,
    input wire logic mca_to_bus_error_signal_in,
    input wire logic mca_to_bus_initialization_signal_in,
    input wire logic corrected_check_interrupt_to_mca_in,
    input wire logic bus_initialization_signal_enable_in,
    input wire logic bus_error_signal_enable_in,
    input wire logic mca_enable_in,
    output logic bus_initialization_signal_out,
    output logic bus_error_signal_out,
    output logic machine_check_abort_out
);
    logic corrected_check_interrupt_promoted;
    logic mca_any;

    assign corrected_check_interrupt_promoted = corrected_check_interrupt_in & corrected_check_interrupt_to_mca_in & mca_enable_in;
    assign mca_any = machine_check_abort_in | corrected_check_interrupt_promoted;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            machine_check_abort_out <= 1'b0;
        end else begin
            machine_check_abort_out <= mca_any & mca_enable_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bus_error_signal_out <= 1'b0;
        end else begin
            bus_error_signal_out <= mca_any & mca_to_bus_error_signal_in & bus_error_signal_enable_in;
        end
    end

    // Both promotion paths share the one bus-init pulse
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bus_initialization_signal_out <= 1'b0;
        end else begin
            bus_initialization_signal_out <= bus_initialization_signal_enable_in &
                ((bus_error_evt_in & bus_error_signal_to_bus_initialization_signal_in) | (mca_any & mca_to_bus_initialization_signal_in));
        end
    end

    sequence s_bus_error_signal_promo;
        bus_error_evt_in && bus_error_signal_to_bus_initialization_signal_in && bus_initialization_signal_enable_in;
    endsequence

    sequence s_corrected_check_interrupt_full;
        corrected_check_interrupt_in && corrected_check_interrupt_to_mca_in && mca_enable_in;
    endsequence

    AST_BUS_ERROR_SIGNAL_TO_BUS_INITIALIZATION_SIGNAL: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_bus_error_signal_promo |=> bus_initialization_signal_out)
        else $error("bus error not promoted to bus init");

    AST_MCA_TO_BUS_ERROR_SIGNAL: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        bus_error_signal_out |-> $past(mca_to_bus_error_signal_in) && $past(bus_error_signal_enable_in))
        else $error("bus error driven without enabled promotion");

    AST_MCA_TO_BUS_INITIALIZATION_SIGNAL: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        machine_check_abort_in && mca_to_bus_initialization_signal_in && bus_initialization_signal_enable_in
        |=> bus_initialization_signal_out)
        else $error("machine check not promoted to bus init");

    AST_CORRECTED_CHECK_INTERRUPT_CHAIN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_corrected_check_interrupt_full ##0 (mca_to_bus_error_signal_in && bus_error_signal_enable_in)
        |=> machine_check_abort_out && bus_error_signal_out)
        else $error("corrected check not escalated");

    AST_BUS_INITIALIZATION_SIGNAL_GATED: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !bus_initialization_signal_enable_in |=> !bus_initialization_signal_out)
        else $error("bus init driven while disabled");
endmodule : pfc_escalate

//--- test/pfc_bus_model.sv
module pfc_bus_model (
    input wire logic sys_clk_in,
    input wire logic fire_in,
    input wire logic [2:0] en_req_in,
    output logic bus_error_pin_out,
    output logic [2:0] enables_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Signalling enables come from the bus option logic as plain levels
    assign enables_out = en_req_in;
    initial begin
        bus_error_pin_out = 1'b0;
        forever begin
            @(posedge fire_in);
            // Pin is asynchronous, so its edge lands mid-cycle
            #7;
            bus_error_pin_out = 1'b1;
            repeat (4) @(posedge sys_clk_in);
            #3;
            bus_error_pin_out = 1'b0;
        end
    end
endmodule : pfc_bus_model

//--- test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] WMASK = pfc_pkg::SET0_AVAIL & pfc_pkg::SET0_CONTROL;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic call_valid = 1'b0;
    logic call_update = 1'b0;
    logic [7:0] call_set = 8'h00;
    logic [63:0] call_data = 64'h0;
    logic [10:0] ev = 11'h000;
    logic fire = 1'b0;
    logic pin_mode = 1'b0;
    logic [2:0] en;
    logic bus_error_signal_pin;
    logic resp_valid, bus_initialization_signal_o, bus_error_signal_o, mca_o, rfc, rtm, coh_o, cst_o, srv, srh, cdis;
    logic [7:0] resp_status;
    logic [63:0] r_av, r_st, r_ct;
    logic [63:0] set_m = 64'h0;
    logic [63:0] x_av, x_st, x_ct;
    logic [7:0] x_stat;
    logic [9:0] x_sig = 10'h000;
    logic x_rv = 1'b0;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int cnt;
    int seed_rs;
    int r;

    always #12.5 sys_clk = ~sys_clk;

    pfc_bus_model u_pfc_bus_model (.sys_clk_in(sys_clk), .fire_in(fire), .en_req_in(ev[8:6]),
        .bus_error_pin_out(bus_error_signal_pin), .enables_out(en));

    pfc_feature_bank u_pfc_feature_bank (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
        .call_valid_in(call_valid), .call_update_in(call_update), .call_set_in(call_set),
        .call_data_in(call_data), .resp_valid_out(resp_valid), .resp_status_out(resp_status),
        .resp_avail_out(r_av), .resp_settings_out(r_st), .resp_control_out(r_ct),
        .bus_error_pin_in(bus_error_signal_pin), .machine_check_abort_in(ev[9]),
        .corrected_check_interrupt_in(ev[10]), .bus_initialization_signal_enable_in(en[2]),
        .bus_error_signal_enable_in(en[1]), .mca_enable_in(en[0]),
        .bus_initialization_signal_out(bus_initialization_signal_o), .bus_error_signal_out(bus_error_signal_o),
        .machine_check_abort_out(mca_o), .ref_valid_in(ev[5]), .ref_hit_in(ev[4]),
        .coherence_req_in(ev[3]), .castout_req_in(ev[2]), .snoop_valid_in(ev[1]),
        .snoop_hit_in(ev[0]), .ref_from_cache_out(rfc), .ref_to_memory_out(rtm),
        .coherence_req_out(coh_o), .castout_req_out(cst_o), .snoop_resp_valid_out(srv),
        .snoop_resp_hit_out(srh), .cache_disabled_out(cdis));

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // One cycle: drive new inputs, check what the last inputs produced, predict
    task automatic step(input logic cv, input logic cu, input logic [7:0] cs,
                        input logic [63:0] cd, input logic [10:0] sv);
        logic pa;
        logic c59;
        @(posedge sys_clk);
        call_valid <= cv;
        call_update <= cu;
        call_set <= cs;
        call_data <= cd;
        ev <= sv;
        #1;
        if (pin_mode && bus_initialization_signal_o === 1'b1)
            cnt++;
        chk("resp_valid", 64'(x_rv), 64'(resp_valid));
        if (x_rv) begin
            chk("resp_status", 64'(x_stat), 64'(resp_status));
            chk("resp_avail", x_av, r_av);
            chk("resp_settings", x_st, r_st);
            chk("resp_control", x_ct, r_ct);
        end
        chk("side_outputs", 64'(x_sig), 64'({bus_initialization_signal_o & !pin_mode, bus_error_signal_o, mca_o, rfc, rtm,
            coh_o, cst_o, srv, srh, cdis}));
        c59 = set_m[59];
        pa = sv[9] | (sv[10] & set_m[60] & sv[6]);
        x_sig[9] = sv[8] & set_m[61] & pa;
        x_sig[8] = sv[7] & set_m[62] & pa;
        x_sig[7] = sv[6] & (sv[9] | (sv[10] & set_m[60]));
        // Firmware takes nothing from the cache while it is off
        x_sig[6] = sv[5] & sv[4] & !c59;
        x_sig[5] = sv[5] & (!sv[4] | c59);
        x_sig[4] = sv[3] & !c59;
        x_sig[3] = sv[2] & !c59;
        x_sig[2] = sv[1];
        x_sig[1] = sv[1] & sv[0] & !c59;
        x_sig[0] = c59;
        x_rv = cv;
        x_av = 64'h0;
        x_st = 64'h0;
        x_ct = 64'h0;
        if (cs == 8'h00) begin
            x_stat = 8'h00;
            x_av = pfc_pkg::SET0_AVAIL;
            x_ct = pfc_pkg::SET0_CONTROL;
            if (cv && cu)
                set_m = (set_m & ~WMASK) | (cd & WMASK);
            x_st = set_m;
        end else if (cs == 8'h10) begin
            x_stat = cu ? 8'hfd : 8'h00;
        end else begin
            x_stat = (cs < 8'h10) ? 8'hfe : 8'hf8;
        end
    endtask : step

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        seed_rs = $urandom(32'h73df);
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        step(1'b1, 1'b0, 8'h00, 64'h0, 11'h000);
        for (int s = 0; s < 20; s++) begin
            step(1'b1, 1'b0, s[7:0], 64'h0, 11'h000);
        end
        step(1'b1, 1'b0, 8'hff, 64'h0, 11'h000);
        for (int s = 0; s < 18; s++) begin
            step(1'b1, 1'b1, s[7:0], '1, 11'h7ff);
        end
        for (int i = 0; i < 400; i++) begin
            r = $urandom_range(0, 7);
            step(r < 6, r[0], (r < 4) ? 8'h00 : 8'($urandom_range(1, 20)),
                {$urandom, $urandom}, 11'($urandom));
        end
        // Pin path goes through a synchroniser, so only the pulse count is fixed
        for (int k = 0; k < 4; k++) begin
            step(1'b1, 1'b1, 8'h00, {k[0], 63'h0}, 11'(k[1]) << 8);
            pin_mode = 1'b1;
            cnt = 0;
            fire = 1'b1;
            repeat (10) step(1'b0, 1'b0, 8'h00, 64'h0, 11'(k[1]) << 8);
            fire = 1'b0;
            pin_mode = 1'b0;
            chk("bus_initialization_signal_pulses", 64'(k == 3), 64'(cnt));
        end
        step(1'b0, 1'b0, 8'h00, 64'h0, 11'h000);
        give_verdict();
    end
endmodule : tb_top
